// ==== core/hwd_regs.svh ====
`ifndef HWD_REGS_SVH
`define HWD_REGS_SVH
`define HWD_ADR_CTRL 4'h0
`define HWD_ADR_PULL 4'h1
`define HWD_ADR_STAT0 4'h2
`define HWD_ADR_STAT1 4'h3
`define HWD_ADR_LVL 4'h4
`define HWD_ADR_MODE 4'h5
`define HWD_CTRL_WAKE_EN 0
`define HWD_CTRL_CYCLIC 1
`define HWD_CTRL_ALT_EN 2
`define HWD_CTRL_MEAS 3
`define HWD_CTRL_RST 8'h00
`define HWD_PULL_RST 8'h00
`define HWD_MODE_RST 8'h00
`define HWD_FILT_NS 16000
`define HWD_CLK_NS 10
`define HWD_FILT_CYC (`HWD_FILT_NS / `HWD_CLK_NS)
`endif

// ==== core/hwd_pkg.sv ====
package hwd_pkg;
	typedef enum logic [1:0] {
		HWD_PULL_NONE = 2'h0,
		HWD_PULL_DOWN = 2'h1,
		HWD_PULL_UP = 2'h2,
		HWD_PULL_AUTO = 2'h3
	} hwd_pull_t;
	typedef enum logic [1:0] {
		HWD_MODE_NORMAL = 2'h0,
		HWD_MODE_STOP = 2'h1,
		HWD_MODE_SLEEP = 2'h2,
		HWD_MODE_FAILSAFE = 2'h3
	} hwd_sbc_mode_t;
endpackage : hwd_pkg

// ==== core/hwd_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hwd_regs.svh"
module hwd_filter (
	input wire logic clk,
	input wire logic nrst,
	input wire logic raw,
	output logic level,
	output logic event_pulse
);
	typedef enum logic {FLT_IDLE, FLT_WAIT} hwd_flt_state_t;
	localparam logic [10:0] FILT_LAST = 11'(`HWD_FILT_CYC - 1);
	hwd_flt_state_t st_r, st_nxt;
	logic [10:0] cnt_r, cnt_nxt;
	logic level_r, level_nxt;
	logic ev_r, ev_nxt;
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		level_nxt = level_r;
		ev_nxt = 1'b0;
		case (st_r)
			FLT_IDLE: begin
				if (raw != level_r) begin
					st_nxt = FLT_WAIT;
					cnt_nxt = 11'h000;
				end
			end
			FLT_WAIT: begin
				if (raw == level_r) begin
					st_nxt = FLT_IDLE;
				end else if (cnt_r == FILT_LAST) begin
					st_nxt = FLT_IDLE;
					level_nxt = raw;
					ev_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r + 11'h001;
				end
			end
			default: st_nxt = FLT_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= FLT_IDLE;
			cnt_r <= 11'h000;
			level_r <= 1'b0;
			ev_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
			ev_r <= ev_nxt;
		end
	end
	assign level = level_r;
	assign event_pulse = ev_r;
endmodule : hwd_filter
`default_nettype wire

// ==== core/hwd_wake_input.sv ====
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "hwd_regs.svh"
module hwd_wake_input
	import hwd_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [7:0] WB_DAT_I,
	output logic [7:0] WB_DAT_O,
	input wire logic WB_WE_I,
	input wire logic WB_SEL_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	input wire logic HV_WAKE_PIN,
	input wire logic FAIL_OR_GENERAL_PIN,
	input wire logic SENSE_WINDOW,
	input wire logic INIT_MODE,
	output logic WAKE_IRQ,
	output logic DEVICE_WAKEUP,
	output logic PULL_UP_EN,
	output logic PULL_DOWN_EN
);
	logic [1:0] wk_sync_r, gp_sync_r, win_sync_r;
	logic wk_s, gp_s, win_s;
	logic wk_level, wk_ev, gp_level, gp_ev;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] pull_r, pull_nxt;
	logic [7:0] mode_r, mode_nxt;
	logic wk_flag_r, wk_flag_nxt;
	logic gp_flag_r, gp_flag_nxt;
	logic lvl_r, lvl_nxt;
	logic samp_r, samp_nxt;
	logic win_d_r, win_d_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] dat_r, dat_nxt;
	logic irq_r, irq_nxt;
	logic wup_r, wup_nxt;
	logic wake_en, cyclic, alt_en, meas;
	logic win_end, cyc_ev, pin_ev, alt_ev, any_ev, active_mode;
	logic req, wr, rd;
	hwd_pull_t pull_sel;
	hwd_sbc_mode_t sbc_mode;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wk_sync_r <= 2'h0;
			gp_sync_r <= 2'h0;
			win_sync_r <= 2'h0;
		end else begin
			wk_sync_r <= {wk_sync_r[0], HV_WAKE_PIN};
			gp_sync_r <= {gp_sync_r[0], FAIL_OR_GENERAL_PIN};
			win_sync_r <= {win_sync_r[0], SENSE_WINDOW};
		end
	end
	assign wk_s = wk_sync_r[1];
	assign gp_s = gp_sync_r[1];
	assign win_s = win_sync_r[1];
	hwd_filter u_wk_filter (
		.clk(CLK),
		.nrst(NRST),
		.raw(wk_s),
		.level(wk_level),
		.event_pulse(wk_ev)
	);
	hwd_filter u_gp_filter (
		.clk(CLK),
		.nrst(NRST),
		.raw(gp_s),
		.level(gp_level),
		.event_pulse(gp_ev)
	);
	assign wake_en = ctrl_r[`HWD_CTRL_WAKE_EN];
	assign cyclic = ctrl_r[`HWD_CTRL_CYCLIC];
	assign alt_en = ctrl_r[`HWD_CTRL_ALT_EN];
	assign meas = ctrl_r[`HWD_CTRL_MEAS];
	assign pull_sel = hwd_pull_t'(pull_r[1:0]);
	assign sbc_mode = hwd_sbc_mode_t'(mode_r[1:0]);
	// sample taken on the falling edge of the timer window
	assign win_end = win_d_r & ~win_s;
	assign cyc_ev = win_end & (wk_s != samp_r);
	assign pin_ev = ~meas & wake_en & (cyclic ? cyc_ev : wk_ev);
	assign alt_ev = ~meas & alt_en & gp_ev;
	assign any_ev = pin_ev | alt_ev;
	assign active_mode = (sbc_mode == HWD_MODE_NORMAL) | (sbc_mode == HWD_MODE_STOP);
	assign req = WB_CYC_I & WB_STB_I & ~ack_r;
	assign wr = req & WB_WE_I & WB_SEL_I;
	assign rd = req & ~WB_WE_I;
	always_comb begin
		ctrl_nxt = ctrl_r;
		pull_nxt = pull_r;
		mode_nxt = mode_r;
		wk_flag_nxt = wk_flag_r;
		gp_flag_nxt = gp_flag_r;
		lvl_nxt = lvl_r;
		samp_nxt = samp_r;
		win_d_nxt = win_s;
		ack_nxt = req;
		dat_nxt = dat_r;
		irq_nxt = any_ev & active_mode;
		wup_nxt = any_ev & ~active_mode;
		if (wr) begin
			case (WB_ADR_I)
				`HWD_ADR_CTRL: ctrl_nxt = WB_DAT_I;
				`HWD_ADR_PULL: pull_nxt = WB_DAT_I;
				`HWD_ADR_MODE: mode_nxt = WB_DAT_I;
				`HWD_ADR_STAT0: if (WB_DAT_I[0]) wk_flag_nxt = 1'b0;
				`HWD_ADR_STAT1: if (WB_DAT_I[0]) gp_flag_nxt = 1'b0;
				default: ;
			endcase
		end
		if (pin_ev) begin
			wk_flag_nxt = 1'b1;
		end
		if (alt_ev) begin
			gp_flag_nxt = 1'b1;
		end
		if (win_end) begin
			samp_nxt = wk_s;
		end
		if (meas) begin
			lvl_nxt = 1'b0;
		end else if (cyclic) begin
			if (win_end) begin
				lvl_nxt = wk_s;
			end
		end else if (active_mode | INIT_MODE) begin
			lvl_nxt = wk_level;
		end
		if (rd) begin
			case (WB_ADR_I)
				`HWD_ADR_CTRL: dat_nxt = ctrl_r;
				`HWD_ADR_PULL: dat_nxt = pull_r;
				`HWD_ADR_MODE: dat_nxt = mode_r;
				`HWD_ADR_STAT0: dat_nxt = {7'h00, wk_flag_r};
				`HWD_ADR_STAT1: dat_nxt = {7'h00, gp_flag_r};
				`HWD_ADR_LVL: dat_nxt = {7'h00, lvl_r};
				default: dat_nxt = 8'h00;
			endcase
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_r <= `HWD_CTRL_RST;
			pull_r <= `HWD_PULL_RST;
			mode_r <= `HWD_MODE_RST;
			wk_flag_r <= 1'b0;
			gp_flag_r <= 1'b0;
			lvl_r <= 1'b0;
			samp_r <= 1'b0;
			win_d_r <= 1'b0;
			ack_r <= 1'b0;
			dat_r <= 8'h00;
			irq_r <= 1'b0;
			wup_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			pull_r <= pull_nxt;
			mode_r <= mode_nxt;
			wk_flag_r <= wk_flag_nxt;
			gp_flag_r <= gp_flag_nxt;
			lvl_r <= lvl_nxt;
			samp_r <= samp_nxt;
			win_d_r <= win_d_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			irq_r <= irq_nxt;
			wup_r <= wup_nxt;
		end
	end
	always_comb begin
		PULL_UP_EN = 1'b0;
		PULL_DOWN_EN = 1'b0;
		if (!meas) begin
			case (pull_sel)
				HWD_PULL_DOWN: PULL_DOWN_EN = 1'b1;
				HWD_PULL_UP: PULL_UP_EN = 1'b1;
				HWD_PULL_AUTO: begin
					PULL_UP_EN = wk_level;
					PULL_DOWN_EN = ~wk_level;
				end
				default: ;
			endcase
		end
	end
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
	assign WAKE_IRQ = irq_r;
	assign DEVICE_WAKEUP = wup_r;
endmodule : hwd_wake_input
`default_nettype wire

// ==== verification/hwd_switch_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module hwd_switch_model (
	input wire logic clk,
	input wire logic target,
	output logic pin
);
	initial pin = 1'b0;
	// every throw bounces back once before it settles
	always @(target) begin
		@(posedge clk) pin <= target;
		repeat (40) @(posedge clk);
		pin <= ~target;
		repeat (20) @(posedge clk);
		pin <= target;
	end
endmodule : hwd_switch_model
`default_nettype wire

// ==== verification/hwd_wake_input_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module hwd_wake_input_props (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic HV_WAKE_PIN,
	input wire logic FAIL_OR_GENERAL_PIN,
	input wire logic SENSE_WINDOW,
	input wire logic WAKE_IRQ,
	input wire logic DEVICE_WAKEUP,
	input wire logic PULL_UP_EN,
	input wire logic PULL_DOWN_EN
);
	// cycles since a pin moved or the sense window was open
	logic [11:0] q_r, q_nxt;
	logic [1:0] d_r;
	wire logic evt = WAKE_IRQ || DEVICE_WAKEUP;
	wire logic mv = ({HV_WAKE_PIN, FAIL_OR_GENERAL_PIN} != d_r) || SENSE_WINDOW;
	always_comb begin
		q_nxt = mv ? 12'h000 : q_r + 12'(q_r != 12'hfff);
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			{q_r, d_r} <= '0;
		end else begin
			{q_r, d_r} <= {q_nxt, HV_WAKE_PIN, FAIL_OR_GENERAL_PIN};
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
	property p_ack; s_req |=> WB_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1; WB_ACK_O |=> !WB_ACK_O; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_stray; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
	a_stray: assert property (p_stray) else $error("stray ack");
	property p_rst; $rose(NRST) |-> !(evt || WB_ACK_O || PULL_UP_EN || PULL_DOWN_EN); endproperty
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
	property p_evt1; evt |=> !evt; endproperty
	a_evt1: assert property (p_evt1) else $error("event pulse long");
	property p_route; !(WAKE_IRQ && DEVICE_WAKEUP); endproperty
	a_route: assert property (p_route) else $error("both routes");
	property p_pull; !(PULL_UP_EN && PULL_DOWN_EN); endproperty
	a_pull: assert property (p_pull) else $error("both pulls on");
	property p_quiet; q_r > 12'h6a4 |-> !evt; endproperty
	a_quiet: assert property (p_quiet) else $error("event on quiet pin");
endmodule : hwd_wake_input_props
bind hwd_wake_input hwd_wake_input_props hwd_wake_input_props_i (.CLK(CLK), .NRST(NRST),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .HV_WAKE_PIN(HV_WAKE_PIN),
	.FAIL_OR_GENERAL_PIN(FAIL_OR_GENERAL_PIN), .SENSE_WINDOW(SENSE_WINDOW), .WAKE_IRQ(WAKE_IRQ),
	.DEVICE_WAKEUP(DEVICE_WAKEUP), .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN));
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hwd_regs.svh"
module tb
	import hwd_pkg::*;
;
	logic clk = 1'b0, nrst = 1'b0, we = 1'b0, sel = 1'b0, cyc = 1'b0, win = 1'b0;
	logic hv_t = 1'b0, alt_t = 1'b0, ack, irq, wup, pu, pd, hv, alt;
	logic init = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [7:0] dat = 8'h00, rdat, q;
	int error_cnt = 0, checks_done = 0, irq_n = 0, wup_n = 0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		irq_n <= irq_n + (irq === 1'b1);
		wup_n <= wup_n + (wup === 1'b1);
	end
	hwd_switch_model sw_hv_i (.clk(clk), .target(hv_t), .pin(hv));
	hwd_switch_model sw_alt_i (.clk(clk), .target(alt_t), .pin(alt));
	hwd_wake_input hwd_wake_input_i (.CLK(clk), .NRST(nrst), .WB_ADR_I(adr), .WB_DAT_I(dat),
		.WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_ACK_O(ack), .HV_WAKE_PIN(hv), .FAIL_OR_GENERAL_PIN(alt), .SENSE_WINDOW(win),
		.INIT_MODE(init), .WAKE_IRQ(irq), .DEVICE_WAKEUP(wup), .PULL_UP_EN(pu), .PULL_DOWN_EN(pd));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic w = 1'b1);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		sel <= 1'b1;
		adr <= a;
		dat <= d;
		// the wait ends on ack; only the watchdog ends it if ack never comes
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		wr(a, 8'h00, 1'b0);
		chk(q, exp);
	endtask : rd
	task automatic pulse;
		win <= 1'b1;
		repeat (10) @(posedge clk);
		win <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : pulse
	task automatic complete_run;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(`HWD_ADR_CTRL, `HWD_CTRL_RST);
		rd(`HWD_ADR_PULL, `HWD_PULL_RST);
		rd(4'hf, 8'h00);
		wr(`HWD_ADR_CTRL, 8'h01);
		wr(`HWD_ADR_PULL, {6'h00, HWD_PULL_AUTO});
		hv_t <= 1'b1;
		repeat (1500) @(posedge clk);
		chk(irq_n[7:0], 8'h00);
		repeat (300) @(posedge clk);
		chk(irq_n[7:0], 8'h01);
		rd(`HWD_ADR_STAT0, 8'h01);
		rd(`HWD_ADR_LVL, 8'h01);
		chk({6'h00, pu, pd}, 8'h02);
		wr(`HWD_ADR_STAT0, 8'h01);
		wr(`HWD_ADR_MODE, {6'h00, HWD_MODE_SLEEP});
		hv_t <= 1'b0;
		repeat (1800) @(posedge clk);
		chk({irq_n[3:0], wup_n[3:0]}, 8'h11);
		chk({6'h00, pu, pd}, 8'h01);
		rd(`HWD_ADR_LVL, 8'h01);
		init <= 1'b1;
		repeat (5) @(posedge clk);
		rd(`HWD_ADR_LVL, 8'h00);
		init <= 1'b0;
		wr(`HWD_ADR_MODE, 8'h00);
		wr(`HWD_ADR_CTRL, 8'h00);
		wr(`HWD_ADR_STAT0, 8'h01);
		hv_t <= 1'b1;
		repeat (1800) @(posedge clk);
		rd(`HWD_ADR_STAT0, 8'h00);
		wr(`HWD_ADR_CTRL, 8'h05);
		alt_t <= 1'b1;
		repeat (1800) @(posedge clk);
		rd(`HWD_ADR_STAT1, 8'h01);
		wr(`HWD_ADR_CTRL, 8'h09);
		rd(`HWD_ADR_LVL, 8'h00);
		chk({6'h00, pu, pd}, 8'h00);
		wr(`HWD_ADR_CTRL, 8'h03);
		pulse;
		wr(`HWD_ADR_STAT0, 8'h01);
		hv_t <= 1'b0;
		repeat (100) @(posedge clk);
		rd(`HWD_ADR_LVL, 8'h01);
		pulse;
		rd(`HWD_ADR_STAT0, 8'h01);
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run;
	end
endmodule : tb
`default_nettype wire
